// ===== rtl/seh_error_handler.sv
// Error status, mode control and data keep/drop decisions for the serial link.
`timescale 1ns/1ns
`default_nettype none
module seh_error_handler
  import seh_pkg::*;
#(
  parameter int FIELD_CYCLES = FIELD_CYC_DEF,
  parameter int CNT_W        = 16
) (
  input  wire logic       CORE_CLK_I,
  input  wire logic       RST_N_I,
  input  wire logic       LINE_I,
  input  wire logic       START_I,
  input  wire logic       FIELD_DONE_I,
  input  wire logic       END_I,
  input  wire logic       WRITE_MODE_I,
  input  wire logic       BLOCK_OK_I,
  input  wire seh_err_t   ERR_EV_I,
  input  wire seh_rd_t    RD_I,
  output logic [1:0]      MODE_O,
  output logic [6:0]      ERR_STATUS_O,
  output logic [7:0]      RD_DATA_O,
  output logic            COMMIT_O,
  output logic            DISCARD_O,
  output logic            IGNORE_O
);

  localparam logic [CNT_W-1:0] TIMEOUT_CYC = CNT_W'(TIMEOUT_FIELDS * FIELD_CYCLES + 1);
  localparam logic [CNT_W-1:0] IDLE_CYC    = CNT_W'(IDLE_FIELDS * FIELD_CYCLES + 1);
  localparam logic [CNT_W-1:0] CNT_ONE     = CNT_W'(1);

  // Whole state of the block in one record.
  typedef struct packed {
    logic             line_s1;
    logic             line_s2;
    seh_mode_t        mode;
    logic [CNT_W-1:0] cnt;
    logic [6:0]       flags;
    logic [7:0]       rd_data;
    logic             commit;
    logic             discard;
    logic             ignore;
  } seh_state_t;

  seh_state_t st_q;
  seh_state_t st_d;
  logic [6:0] set_v;
  logic       clr;
  logic       fatal;

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic.
  ////////////////////////////////////////////////////////////////////////////

  // Errors are only taken outside error mode; in error mode the decoder is deaf.
  always_comb begin
    st_d         = st_q;
    st_d.line_s1 = LINE_I;
    st_d.line_s2 = st_q.line_s1;
    st_d.commit  = 1'b0;
    st_d.discard = 1'b0;
    st_d.ignore  = 1'b0;
    set_v        = '0;
    fatal        = 1'b0;
    clr          = RD_I.stb && RD_I.addr == ERR_STATUS_ADDR && RD_I.len == SINGLE_LEN;
    if (st_q.mode != SEH_ERROR) begin
      set_v[BIT_FRAMING]    = ERR_EV_I.framing;
      set_v[BIT_HEADER]     = ERR_EV_I.header;
      set_v[BIT_RW_PARITY]  = ERR_EV_I.rw_parity;
      set_v[BIT_LEN_PARITY] = ERR_EV_I.len_parity;
      set_v[BIT_CHECKSUM]   = ERR_EV_I.checksum && WRITE_MODE_I;
      set_v[BIT_RW_DATA]    = ERR_EV_I.rw_data;
      fatal = |set_v[BIT_CHECKSUM:BIT_FRAMING];
    end
    // Read data is latched before the clear so a clearing read still sees the flags.
    if (RD_I.stb && RD_I.addr == ERR_STATUS_ADDR) begin
      st_d.rd_data = {1'b0, st_q.flags};
    end
    case (st_q.mode)
      SEH_STANDBY: begin
        st_d.cnt = '0;
        if (fatal) begin
          st_d.mode = SEH_ERROR;
        end else if (START_I) begin
          st_d.mode = SEH_COMM;
        end
      end
      SEH_COMM: begin
        st_d.cnt = (FIELD_DONE_I || START_I) ? '0 : st_q.cnt + CNT_ONE;
        if (st_q.cnt >= TIMEOUT_CYC) begin
          // Good blocks were committed on their own; only the open one is dropped.
          set_v[BIT_TIMEOUT] = 1'b1;
          st_d.mode    = SEH_STANDBY;
          st_d.discard = 1'b1;
          st_d.cnt     = '0;
        end else if (fatal) begin
          st_d.mode    = SEH_ERROR;
          st_d.discard = WRITE_MODE_I;
          st_d.cnt     = '0;
        end else if (set_v[BIT_RW_DATA]) begin
          st_d.ignore  = 1'b1;
          st_d.discard = WRITE_MODE_I;
        end else begin
          st_d.commit = BLOCK_OK_I && WRITE_MODE_I;
          if (END_I) begin
            st_d.mode = SEH_STANDBY;
          end
        end
      end
      SEH_ERROR: begin
        // Any low on the line restarts the idle interval; flags are not looked at.
        st_d.cnt = (st_q.line_s2 == LINE_IDLE) ? st_q.cnt + CNT_ONE : '0;
        if (st_q.cnt >= IDLE_CYC) begin
          st_d.mode = SEH_STANDBY;
          st_d.cnt  = '0;
        end
      end
      default: begin
        st_d.mode = SEH_STANDBY;
        st_d.cnt  = '0;
      end
    endcase
    // A new error wins over a clearing read in the same cycle.
    st_d.flags = (clr ? ERR_RESET : st_q.flags) | set_v;
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register.
  ////////////////////////////////////////////////////////////////////////////

  // Synchronous reset; flags hold through every mode change until a single-byte read.
  always_ff @(posedge CORE_CLK_I) begin
    if (!RST_N_I) begin
      st_q.line_s1 <= LINE_IDLE;
      st_q.line_s2 <= LINE_IDLE;
      st_q.mode    <= SEH_STANDBY;
      st_q.cnt     <= '0;
      st_q.flags   <= ERR_RESET;
      st_q.rd_data <= '0;
      st_q.commit  <= 1'b0;
      st_q.discard <= 1'b0;
      st_q.ignore  <= 1'b0;
    end else begin
      st_q <= st_d;
    end
  end

  // Outputs come straight from the state record.
  assign MODE_O       = st_q.mode;
  assign ERR_STATUS_O = st_q.flags;
  assign RD_DATA_O    = st_q.rd_data;
  assign COMMIT_O     = st_q.commit;
  assign DISCARD_O    = st_q.discard;
  assign IGNORE_O     = st_q.ignore;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions.
  ////////////////////////////////////////////////////////////////////////////

  a_chk_to_error: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
    (st_q.mode == SEH_COMM && st_q.cnt < TIMEOUT_CYC && ERR_EV_I.checksum && WRITE_MODE_I)
    |=> (st_q.mode == SEH_ERROR && st_q.flags[BIT_CHECKSUM] && DISCARD_O && !COMMIT_O))
    else $error("checksum error did not reach error mode");

  a_timeout_standby: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
    (st_q.mode == SEH_COMM && st_q.cnt >= TIMEOUT_CYC)
    |=> (st_q.mode == SEH_STANDBY && st_q.flags[BIT_TIMEOUT]))
    else $error("timeout did not flag and drop to standby");

  a_idle_recover: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
    (st_q.mode == SEH_ERROR && st_q.cnt >= IDLE_CYC) |=> st_q.mode == SEH_STANDBY)
    else $error("error mode did not recover after idle line");

  // The last counted cycle leaves error mode even if the line drops in it.
  a_low_restarts: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
    (st_q.mode == SEH_ERROR && st_q.cnt < IDLE_CYC && st_q.line_s2 != LINE_IDLE)
    |=> (st_q.cnt == '0 && st_q.mode == SEH_ERROR))
    else $error("low line did not restart idle interval");

  a_single_clear: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
    (clr && set_v == '0) |=> (st_q.flags == ERR_RESET && RD_DATA_O == {1'b0, $past(st_q.flags)}))
    else $error("single byte read did not return then clear");

  a_multi_keep: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
    (!clr) |=> ((st_q.flags & $past(st_q.flags)) == $past(st_q.flags)))
    else $error("flags lost without a single byte read");

  a_set_wins: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
    (st_q.mode != SEH_ERROR && ERR_EV_I.framing) |=> st_q.flags[BIT_FRAMING])
    else $error("framing event lost");

  a_data_err_stay: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
    (st_q.mode == SEH_COMM && st_q.cnt < TIMEOUT_CYC && ERR_EV_I.rw_data && !fatal)
    |=> (st_q.mode == SEH_COMM && IGNORE_O && st_q.flags[BIT_RW_DATA]))
    else $error("data error ended communication");

  a_commit_good: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
    (st_q.mode == SEH_COMM && st_q.cnt < TIMEOUT_CYC && BLOCK_OK_I && WRITE_MODE_I && set_v == '0)
    |=> COMMIT_O ##1 (!COMMIT_O || $past(BLOCK_OK_I)))
    else $error("good block not committed");

  a_read_no_chk: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
    (ERR_EV_I.checksum && !WRITE_MODE_I && !st_q.flags[BIT_CHECKSUM])
    |=> !st_q.flags[BIT_CHECKSUM])
    else $error("checksum flagged outside a write");

  a_timeout_drop: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
    (st_q.mode == SEH_COMM && st_q.cnt >= TIMEOUT_CYC) |=> (DISCARD_O && !COMMIT_O))
    else $error("timeout did not drop the open block");

  a_standby_error: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
    (st_q.mode == SEH_STANDBY && fatal) |=> st_q.mode == SEH_ERROR)
    else $error("error in standby did not enter error mode");

  // Error mode is deaf to events, so only a clearing read may touch the flags there.
  a_error_hold: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
    (st_q.mode == SEH_ERROR && !clr) |=> st_q.flags == $past(st_q.flags))
    else $error("flags changed in error mode without a clearing read");

  a_multi_data: assert property (@(posedge CORE_CLK_I) disable iff (!RST_N_I)
    (RD_I.stb && RD_I.addr == ERR_STATUS_ADDR && RD_I.len != SINGLE_LEN)
    |=> (RD_DATA_O == {1'b0, $past(st_q.flags)}
         && (st_q.flags & $past(st_q.flags)) == $past(st_q.flags)))
    else $error("multi byte read lost or cleared the flags");

endmodule : seh_error_handler
`default_nettype wire

// ===== rtl/seh_pkg.sv
// Package with constants and types for the serial link error handler.
package seh_pkg;

  // Link modes.
  typedef enum logic [1:0] {
    SEH_STANDBY = 2'b00,
    SEH_COMM    = 2'b01,
    SEH_ERROR   = 2'b10
  } seh_mode_t;

  // Status register placement and layout.
  localparam logic [15:0] ERR_STATUS_ADDR = 16'h0219;
  localparam int          ERR_W           = 7;
  localparam int          BIT_FRAMING     = 0;
  localparam int          BIT_HEADER      = 1;
  localparam int          BIT_RW_PARITY   = 2;
  localparam int          BIT_LEN_PARITY  = 3;
  localparam int          BIT_CHECKSUM    = 4;
  localparam int          BIT_TIMEOUT     = 5;
  localparam int          BIT_RW_DATA     = 6;
  localparam logic [6:0]  ERR_RESET       = 7'h00;
  localparam logic [7:0]  SINGLE_LEN      = 8'h01;
  localparam logic        LINE_IDLE       = 1'b1;

  // Timing: one field time and the clock period, both in ns.
  localparam int CLK_PERIOD_NS  = 20;
  localparam int FIELD_TIME_NS  = 20000;
  localparam int FIELD_CYC_DEF  = FIELD_TIME_NS / CLK_PERIOD_NS;
  localparam int TIMEOUT_FIELDS = 3;
  localparam int IDLE_FIELDS    = 4;

  // Error events reported by the frame decoder, one-cycle pulses.
  typedef struct packed {
    logic rw_data;
    logic checksum;
    logic len_parity;
    logic rw_parity;
    logic header;
    logic framing;
  } seh_err_t;

  // Register read request seen on the link.
  typedef struct packed {
    logic        stb;
    logic [15:0] addr;
    logic [7:0]  len;
  } seh_rd_t;

endpackage : seh_pkg

// ===== sim/seh_error_handler_tb.sv
// Self-checking bench for the serial link error handler.
`timescale 1ns/1ns
`default_nettype none
module seh_error_handler_tb import seh_pkg::*; ();
  logic       clk;
  logic       rst_n;
  logic       line, start, fdone, fin, wr, blk;
  seh_err_t   ev;
  seh_rd_t    rd;
  logic [1:0] mode;
  logic [6:0] status;
  logic [7:0] rdd;
  logic       commit, discard, ignore;
  int         failures = 0;
  int         num_checks = 0;

  // A short field keeps every gap and idle count to a few cycles.
  seh_error_handler #(.FIELD_CYCLES(4)) DUT (.CORE_CLK_I(clk), .RST_N_I(rst_n),
    .LINE_I(line), .START_I(start), .FIELD_DONE_I(fdone), .END_I(fin), .WRITE_MODE_I(wr),
    .BLOCK_OK_I(blk), .ERR_EV_I(ev), .RD_I(rd), .MODE_O(mode), .ERR_STATUS_O(status),
    .RD_DATA_O(rdd), .COMMIT_O(commit), .DISCARD_O(discard), .IGNORE_O(ignore));
  seh_host_model host (.clk_i(clk), .line_o(line), .start_o(start), .field_o(fdone),
    .end_o(fin), .wr_o(wr), .blk_o(blk), .err_o(ev), .rd_o(rd));

  // Free-running 50 MHz clock.
  always #10 clk = ~clk;

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic wrap_up();
    $display("checks=%0d failures=%0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : wrap_up

  task automatic t_checksum();
    host.begin_frame(1'b1);
    host.fire(6'h00, 1'b1, 1'b1, 1'b0);
    chk(commit, 1'b1);
    host.fire(6'h10, 1'b0, 1'b0, 1'b0);
    chk(mode, SEH_ERROR);
    chk(status, 7'h10);
    chk(discard, 1'b1);
    host.hold_idle(16);
    chk(mode, SEH_ERROR);
    host.hold_idle(14);
    chk(mode, SEH_STANDBY);
    chk(status, 7'h10);
    host.read_status(8'h02, 6'h00);
    chk(rdd, 8'h10);
    chk(status, 7'h10);
    host.read_status(SINGLE_LEN, 6'h00);
    chk(rdd, 8'h10);
    chk(status, ERR_RESET);
    $display("test checksum done");
  endtask : t_checksum

  // The four fatal events other than checksum sit in status bits 0 to 3 in event order.
  task automatic t_fatal();
    for (int i = 0; i < 4; i++) begin
      host.begin_frame(1'b0);
      host.fire(seh_err_t'(6'h01 << i), 1'b0, 1'b0, 1'b0);
      chk(mode, SEH_ERROR);
      chk(status, 7'h01 << i);
      host.hold_idle(30);
      host.read_status(SINGLE_LEN, 6'h00);
      chk(rdd, 8'h01 << i);
    end
    $display("test fatal done");
  endtask : t_fatal

  // With four-cycle fields the gap limit is 13 idle cycles, so the last comm
  // check sits one cycle before the drop and the discard pulse is caught live.
  task automatic t_timeout();
    host.begin_frame(1'b1);
    host.fire(6'h00, 1'b1, 1'b1, 1'b0);
    chk(commit, 1'b1);
    repeat (13) @(negedge clk);
    chk(mode, SEH_COMM);
    repeat (1) @(negedge clk);
    chk(mode, SEH_STANDBY);
    chk(status, 7'h20);
    chk(discard, 1'b1);
    host.hold_idle(0);
    host.read_status(SINGLE_LEN, 6'h00);
    chk(rdd, 8'h20);
    $display("test timeout done");
  endtask : t_timeout

  task automatic t_rwdata();
    host.begin_frame(1'b1);
    host.fire(6'h20, 1'b0, 1'b0, 1'b0);
    chk(ignore, 1'b1);
    chk(discard, 1'b1);
    chk(mode, SEH_COMM);
    chk(status, 7'h40);
    host.read_status(SINGLE_LEN, 6'h20);
    chk(status, 7'h40);
    host.fire(6'h00, 1'b0, 1'b0, 1'b1);
    chk(mode, SEH_STANDBY);
    $display("test rwdata done");
  endtask : t_rwdata

  // A read frame must shrug off a checksum event, while a header error seen
  // in standby still forces error mode.
  task automatic t_standby();
    host.read_status(SINGLE_LEN, 6'h00);
    chk(rdd, 8'h40);
    host.begin_frame(1'b0);
    host.fire(6'h10, 1'b0, 1'b0, 1'b0);
    chk(mode, SEH_COMM);
    chk(status, ERR_RESET);
    host.fire(6'h00, 1'b0, 1'b0, 1'b1);
    chk(mode, SEH_STANDBY);
    host.fire(6'h02, 1'b0, 1'b0, 1'b0);
    chk(mode, SEH_ERROR);
    chk(status, 7'h02);
    host.hold_idle(30);
    chk(mode, SEH_STANDBY);
    host.read_status(SINGLE_LEN, 6'h00);
    chk(rdd, 8'h02);
    $display("test standby done");
  endtask : t_standby

  // Main sequence; reset is held for eight cycles first.
  initial begin
    clk   = 1'b0;
    rst_n = 1'b0;
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    chk(mode, SEH_STANDBY);
    chk(status, ERR_RESET);
    t_checksum();
    t_fatal();
    t_timeout();
    t_rwdata();
    t_standby();
    wrap_up();
  end

  // The tests need well under ten microseconds, so this only cuts a hang.
  initial begin
    #100000;
    failures++;
    wrap_up();
  end
endmodule : seh_error_handler_tb
`default_nettype wire

// ===== sim/seh_host_model.sv
// Behavioural model of the link master that feeds the decoder events.
`timescale 1ns/1ns
`default_nettype none
module seh_host_model
  import seh_pkg::*;
(
  input  wire logic clk_i,
  output logic      line_o,
  output logic      start_o,
  output logic      field_o,
  output logic      end_o,
  output logic      wr_o,
  output logic      blk_o,
  output seh_err_t  err_o,
  output seh_rd_t   rd_o
);
  // Everything starts quiet with the line at its idle level.
  initial begin
    line_o  = LINE_IDLE;
    start_o = 1'b0;
    field_o = 1'b0;
    end_o   = 1'b0;
    wr_o    = 1'b0;
    blk_o   = 1'b0;
    err_o   = '0;
    rd_o    = '0;
  end

  // A frame pulls the line low, so recovery cannot start mid-frame.
  task automatic begin_frame(input logic wr);
    @(negedge clk_i);
    line_o  = 1'b0;
    wr_o    = wr;
    start_o = 1'b1;
    @(negedge clk_i);
    start_o = 1'b0;
  endtask : begin_frame

  // One cycle of decoder events; the caller sees the answer on return.
  task automatic fire(input seh_err_t ev, input logic fd, input logic blk, input logic fin);
    @(negedge clk_i);
    err_o   = ev;
    field_o = fd;
    blk_o   = blk;
    end_o   = fin;
    @(negedge clk_i);
    err_o   = '0;
    field_o = 1'b0;
    blk_o   = 1'b0;
    end_o   = 1'b0;
  endtask : fire

  // Holding the line high is the only way out of error mode.
  task automatic hold_idle(input int n);
    line_o = LINE_IDLE;
    repeat (n) @(negedge clk_i);
  endtask : hold_idle

  // Status read after a transaction, with an optional event in the same cycle.
  task automatic read_status(input logic [7:0] len, input seh_err_t ev);
    @(negedge clk_i);
    rd_o  = {1'b1, ERR_STATUS_ADDR, len};
    err_o = ev;
    @(negedge clk_i);
    rd_o  = '0;
    err_o = '0;
  endtask : read_status
endmodule : seh_host_model
`default_nettype wire
